// ### rtl/spr_params.svh
// Constants of the inbound side of the serial peer port: offsets, fields, resets, levels.
// Assumes APB byte addresses in the low eight bits and 32-bit register words.
//
// Behaviour
// - Region chosen by cumulative region size sums
// - Local address = packet + offset - lower sizes
// - Address beyond all regions translates to zero
// - Send pause symbol when inbound queues fill
// - Each inbound queue stores sixteen 32-bit words plus a head word
// - Send resume symbol once storage drains to half
// - Software reset bit halts engines, drops link
// - Software reset restores only status register
// - Hardware reset restores all registers, enables link
// - Pending bits set by write, packet, error
// - Remote routing sends pending bits, clears when sent
// - Local routing moves pending bits, pulses interrupt
// - Status write with bits left gives pulse
// - Priority vector reads lowest set bit, write clears in local routing
// - Priority register shows none-pending flag
// - Interrupt packet status written to pointer target when that is pending/set
// - Remote and local error flags set on errors
// - Enabled error posts pending bit at selected position
// - Remote error set at link-up, write-one clears
`ifndef SPR_PARAMS_SVH
`define SPR_PARAMS_SVH

// Register byte offsets
`define SPR_OFF_CTRL      8'h04
`define SPR_OFF_STATUS    8'h08
`define SPR_OFF_PRIO      8'h0C
`define SPR_OFF_STAT_CLR  8'h10
`define SPR_OFF_PEND_SET  8'h14
`define SPR_OFF_PTR       8'h18
`define SPR_OFF_MAP_BASE  8'h20
`define SPR_OFF_MAP_LAST  8'h3C

// Control fields
`define SPR_CTRL_SWRST    0
`define SPR_CTRL_WRLOCAL  7
`define SPR_CTRL_ERRSEL   12:8
`define SPR_CTRL_ERREN    13
`define SPR_CTRL_LOCAL    14

// Status fields
`define SPR_STAT_LINK     0
`define SPR_STAT_REMERR   8
`define SPR_STAT_LOCERR   9

// Priority register fields
`define SPR_PRIO_NONE     31

// Reset values
`define SPR_CTRL_RST      32'h0000_0000
`define SPR_PTR_RST       32'h0000_0000
`define SPR_MAP_RST       32'h0000_0000

// Inbound packet layout and type codes
`define SPR_PKT_BITS      7'h48
`define SPR_PKT_WRITE     8'h01
`define SPR_PKT_IRQ       8'h02

// Queue geometry and resume level
`define SPR_Q_WIDTH       32
`define SPR_Q_DEPTH       16
`define SPR_Q_FULL        5'h10
`define SPR_RESUME_LEVEL  5'h08

`endif

// ### rtl/spr_pkg.sv
// Types shared by the inbound side of the serial peer port.
// Assumes spr_params.svh is visible for field widths.
package spr_pkg;

  // Inbound receive engine
  typedef enum logic [0:0] {RX_IDLE, RX_SHIFT} spr_rx_t;

  // Outbound interrupt packet engine
  typedef enum logic [0:0] {TX_IDLE, TX_WAIT} spr_tx_t;

  // Whole state of the top module
  typedef struct packed {
    logic [31:0]      ctrl;
    logic [3:0][31:0] mapSize;
    logic [3:0][31:0] mapOff;
    logic [31:0]      ptr;
    logic [31:0]      pendSet;
    logic [31:0]      statClr;
    logic             remErr;
    logic             locErr;
    logic [5:0]       syncA;
    logic [5:0]       syncB;
    logic [5:0]       pinPrev;
    spr_rx_t          rxState;
    logic [71:0]      shift;
    logic [6:0]       bitCnt;
    spr_tx_t          txState;
    logic [31:0]      txData;
    logic             paused;
    logic             fcPause;
    logic             fcResume;
    logic             irqPulse;
    logic [31:0]      prdata;
    logic             qPush;
    logic [31:0]      qAddr;
    logic [31:0]      qData;
  } spr_state_t;

  // Whole state of one inbound queue
  typedef struct packed {
    logic [15:0][31:0] mem;
    logic [3:0]        wp;
    logic [3:0]        rp;
    logic [4:0]        cnt;
    logic [31:0]       out;
    logic              outValid;
  } spr_q_state_t;

endpackage

// ### rtl/spr_rxq_if.sv
// Connection between the top module and one inbound queue.
// Assumes one clock domain; the queue pushes and pops on ref_clk.
`timescale 1ns/1ns
interface spr_rxq_if;
  logic        pushValid;  // Word offered to the queue
  logic        pushReady;  // Queue has room
  logic [31:0] pushData;   // Word to store
  logic        popValid;   // Head word present
  logic        popReady;   // Consumer takes head word
  logic [31:0] popData;    // Head word, registered
  logic [4:0]  level;      // Words held, storage only
  logic        flush;      // Drop all contents

  modport queue (input pushValid, pushData, popReady, flush, output pushReady, popValid, popData, level);
  modport user  (output pushValid, pushData, popReady, flush, input pushReady, popValid, popData, level);
endinterface

// ### rtl/spr_rx_queue.sv
// Inbound queue of sixteen 32-bit words with a registered head word.
// Assumes push is offered only while pushReady is high.
`timescale 1ns/1ns
`include "spr_params.svh"
module spr_rx_queue
  import spr_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   nrst,
  spr_rxq_if.queue    q
);

  spr_q_state_t s_q;  // Registered state
  spr_q_state_t s_d;  // Next state

  // Storage level drives back-pressure; head register is extra slack
  assign q.pushReady = (s_q.cnt != `SPR_Q_FULL);
  assign q.popValid  = s_q.outValid;
  assign q.popData   = s_q.out;
  assign q.level     = s_q.cnt;

  // Next-state logic
  always_comb begin
    s_d = s_q;
    if (q.popReady) begin
      s_d.outValid = 1'b0;
    end
    // Refill the head word when it is free or being taken
    if ((!s_q.outValid || q.popReady) && (s_q.cnt != 5'h00)) begin
      s_d.out      = s_q.mem[s_q.rp];
      s_d.outValid = 1'b1;
      s_d.rp       = s_q.rp + 4'h1;
      s_d.cnt      = s_d.cnt - 5'h01;
    end
    // Store an offered word into the ring
    if (q.pushValid && q.pushReady) begin
      s_d.mem[s_q.wp] = q.pushData;
      s_d.wp          = s_q.wp + 4'h1;
      s_d.cnt         = s_d.cnt + 5'h01;
    end
    // Flush wins over everything
    if (q.flush) begin
      s_d.wp       = 4'h0;
      s_d.rp       = 4'h0;
      s_d.cnt      = 5'h00;
      s_d.outValid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Never store beyond sixteen words
  queue_bound_a: assert property (@(posedge ref_clk) disable iff (!nrst) s_q.cnt <= `SPR_Q_FULL)
    else $error("queue level above sixteen");

endmodule

// ### rtl/spr_rx_top.sv
// Inbound side of the serial peer port: translation, flow control, resets, interrupts.
// Assumes an APB master on ref_clk and link pins from another clock, sampled here.
`timescale 1ns/1ns
`include "spr_params.svh"
module spr_rx_top
  import spr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        linkClk,
  input  wire logic        linkData,
  input  wire logic        linkFrame,
  input  wire logic        linkUp,
  input  wire logic        remoteErrIn,
  input  wire logic        txIrqDone,
  output logic             linkEnable,
  output logic             fcPause,
  output logic             fcResume,
  output logic             txIrqValid,
  output logic [31:0]      txIrqData,
  output logic             port_irq_out,
  output logic             rdValid,
  input  wire logic        rdReady,
  output logic [31:0]      rdAddr,
  output logic [31:0]      rdData
);

  // Synchroniser lanes
  localparam int P_CLK = 0;
  localparam int P_DAT = 1;
  localparam int P_FRM = 2;
  localparam int P_UP  = 3;
  localparam int P_REM = 4;
  localparam int P_DON = 5;

  spr_state_t  s_q;          // Registered state
  spr_state_t  s_d;          // Next state
  spr_rxq_if   qa ();        // Translated address queue
  spr_rxq_if   qb ();        // Data queue
  logic [31:0] runSum [4];   // Cumulative region sizes
  logic [31:0] pktAddr;      // Address of a finished packet
  logic [31:0] xlAddr;       // Translated address
  logic        swRst;        // Software reset held
  logic        rxDone;       // Packet of full length just finished
  logic        apbAccess;    // APB access phase
  logic        apbWrite;     // Write takes effect this edge
  logic        mapped;       // Address hits a register
  logic        nonePend;     // Nothing in status/clear

  // Two queues, one per half of a write
  spr_rx_queue uQueueA (.ref_clk(ref_clk), .nrst(nrst), .q(qa.queue));
  spr_rx_queue uQueueB (.ref_clk(ref_clk), .nrst(nrst), .q(qb.queue));

  assign qa.pushValid = s_q.qPush;
  assign qa.pushData  = s_q.qAddr;
  assign qb.pushValid = s_q.qPush;
  assign qb.pushData  = s_q.qData;
  assign qa.popReady  = rdReady && rdValid;
  assign qb.popReady  = rdReady && rdValid;
  assign qa.flush     = swRst;
  assign qb.flush     = swRst;
  assign rdValid      = qa.popValid && qb.popValid;
  assign rdAddr       = qa.popData;
  assign rdData       = qb.popData;

  // Lowest set bit is the most urgent vector
  function automatic logic [4:0] prioIdx(input logic [31:0] bits);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (bits[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // Running sums pick the region; sizes total at most 64 MB so no wrap
  assign runSum[0] = s_q.mapSize[0];
  assign runSum[1] = runSum[0] + s_q.mapSize[1];
  assign runSum[2] = runSum[1] + s_q.mapSize[2];
  assign runSum[3] = runSum[2] + s_q.mapSize[3];
  assign pktAddr   = s_q.shift[63:32];

  // First region whose cumulative size exceeds the address wins
  always_comb begin
    if (pktAddr < runSum[0]) begin
      xlAddr = pktAddr + s_q.mapOff[0];
    end else if (pktAddr < runSum[1]) begin
      xlAddr = pktAddr + s_q.mapOff[1] - runSum[0];
    end else if (pktAddr < runSum[2]) begin
      xlAddr = pktAddr + s_q.mapOff[2] - runSum[1];
    end else if (pktAddr < runSum[3]) begin
      xlAddr = pktAddr + s_q.mapOff[3] - runSum[2];
    end else begin
      xlAddr = 32'h0000_0000;
    end
  end

  assign swRst     = s_q.ctrl[`SPR_CTRL_SWRST];
  assign rxDone    = (s_q.rxState == RX_SHIFT) && (s_q.bitCnt == `SPR_PKT_BITS);
  assign apbAccess = psel && penable;
  assign apbWrite  = apbAccess && pwrite;
  assign nonePend  = (s_q.statClr == 32'h0000_0000);
  assign mapped    = (paddr == `SPR_OFF_CTRL) || (paddr == `SPR_OFF_STATUS) || (paddr == `SPR_OFF_PRIO) ||
                     (paddr == `SPR_OFF_STAT_CLR) || (paddr == `SPR_OFF_PEND_SET) || (paddr == `SPR_OFF_PTR) ||
                     ((paddr >= `SPR_OFF_MAP_BASE) && (paddr <= `SPR_OFF_MAP_LAST) && (paddr[1:0] == 2'b00));

  // Read data is captured in setup, so the access phase never waits
  assign pready     = 1'b1;
  assign pslverr    = apbAccess && !mapped;
  assign prdata     = s_q.prdata;
  assign linkEnable = !swRst;
  assign fcPause    = s_q.fcPause;
  assign fcResume   = s_q.fcResume;
  assign txIrqValid = (s_q.txState == TX_WAIT);
  assign txIrqData  = s_q.txData;
  assign port_irq_out = s_q.irqPulse;

  // All next-state logic
  always_comb begin
    logic        clkRise;     // Link clock edge seen
    logic        remSet;      // Remote error event
    logic        locSet;      // Local error event
    logic [31:0] moved;       // Pending bits handed over locally
    logic [3:0]  mapIdx;      // Map word index
    logic        linkNow;     // Link state seen by status
    clkRise = 1'b0;
    remSet  = 1'b0;
    locSet  = 1'b0;
    moved   = 32'h0000_0000;
    mapIdx  = 4'(paddr[5:2] - 4'h8);
    linkNow = s_q.syncB[P_UP] && !swRst;
    s_d = s_q;
    s_d.fcPause  = 1'b0;
    s_d.fcResume = 1'b0;
    s_d.irqPulse = 1'b0;
    s_d.qPush    = 1'b0;

    // Two flops per pin and a third for edges; the first is never looked at
    s_d.syncA   = {txIrqDone, remoteErrIn, linkUp, linkFrame, linkData, linkClk};
    s_d.syncB   = s_q.syncA;
    s_d.pinPrev = s_q.syncB;
    clkRise     = s_q.syncB[P_CLK] && !s_q.pinPrev[P_CLK];

    // Remote routing: one packet at a time; sent bits clear first so later sets this cycle win
    case (s_q.txState)
      TX_IDLE: begin
        if (!s_q.ctrl[`SPR_CTRL_LOCAL] && (s_q.pendSet != 32'h0000_0000)) begin
          s_d.txData  = s_q.pendSet;
          s_d.txState = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (s_q.syncB[P_DON] && !s_q.pinPrev[P_DON]) begin
          s_d.pendSet = s_q.pendSet & ~s_q.txData;
          s_d.txState = TX_IDLE;
        end
      end
      default: begin
        s_d.txState = TX_IDLE;
      end
    endcase

    // Receive engine: shift on link clock edges inside a frame
    case (s_q.rxState)
      RX_IDLE: begin
        s_d.bitCnt = 7'h00;
        if (s_q.syncB[P_FRM] && clkRise) begin
          s_d.shift   = {s_q.shift[70:0], s_q.syncB[P_DAT]};
          s_d.bitCnt  = 7'h01;
          s_d.rxState = RX_SHIFT;
        end
      end
      RX_SHIFT: begin
        if (rxDone) begin
          s_d.rxState = RX_IDLE;
          if (s_q.shift[71:64] == `SPR_PKT_WRITE) begin
            if (qa.pushReady && qb.pushReady) begin
              s_d.qPush = 1'b1;
              s_d.qAddr = xlAddr;
              s_d.qData = s_q.shift[31:0];
            end else begin
              locSet = 1'b1;  // Peer ignored the pause
            end
          end else if (s_q.shift[71:64] == `SPR_PKT_IRQ) begin
            // Status lands in pending/set only through a local pointer to it
            if (s_q.ctrl[`SPR_CTRL_WRLOCAL] && (s_q.ptr[7:0] == `SPR_OFF_PEND_SET)) begin
              s_d.pendSet = s_d.pendSet | s_q.shift[31:0];
            end
          end else begin
            locSet = 1'b1;
          end
        end else if (!s_q.syncB[P_FRM]) begin
          s_d.rxState = RX_IDLE;
          locSet      = 1'b1;  // Short frame
        end else if (clkRise) begin
          s_d.shift  = {s_q.shift[70:0], s_q.syncB[P_DAT]};
          s_d.bitCnt = s_q.bitCnt + 7'h01;
        end
      end
      default: begin
        s_d.rxState = RX_IDLE;
      end
    endcase

    // Pause when storage is used up, resume when half drains
    if (!s_q.paused && (qa.level == `SPR_Q_FULL)) begin
      s_d.paused  = 1'b1;
      s_d.fcPause = 1'b1;
    end else if (s_q.paused && (qa.level <= `SPR_RESUME_LEVEL)) begin
      s_d.paused   = 1'b0;
      s_d.fcResume = 1'b1;
    end

    // Error events from the peer and from link-up
    if (s_q.syncB[P_REM] && !s_q.pinPrev[P_REM]) begin
      remSet = 1'b1;
    end
    if (s_q.syncB[P_UP] && !s_q.pinPrev[P_UP]) begin
      remSet = 1'b1;
    end

    // APB setup phase captures read data
    if (psel && !penable && !pwrite) begin
      s_d.prdata = 32'h0000_0000;
      case (paddr)
        `SPR_OFF_CTRL:     s_d.prdata = s_q.ctrl;
        `SPR_OFF_STATUS: begin
          s_d.prdata[`SPR_STAT_LINK]   = linkNow;
          s_d.prdata[`SPR_STAT_REMERR] = s_q.remErr;
          s_d.prdata[`SPR_STAT_LOCERR] = s_q.locErr;
        end
        `SPR_OFF_PRIO: begin
          s_d.prdata[4:0]            = prioIdx(s_q.statClr);
          s_d.prdata[`SPR_PRIO_NONE] = nonePend;
        end
        `SPR_OFF_STAT_CLR: s_d.prdata = s_q.statClr;
        `SPR_OFF_PEND_SET: s_d.prdata = s_q.pendSet;
        `SPR_OFF_PTR:      s_d.prdata = s_q.ptr;
        default: begin
          if (mapped && (paddr >= `SPR_OFF_MAP_BASE)) begin
            s_d.prdata = mapIdx[0] ? s_q.mapOff[mapIdx[3:1]] : s_q.mapSize[mapIdx[3:1]];
          end
        end
      endcase
    end

    // Interrupt forwarding by routing mode
    if (s_q.ctrl[`SPR_CTRL_LOCAL]) begin
      moved       = s_q.pendSet;
      s_d.statClr = s_q.statClr | moved;
      s_d.pendSet = s_d.pendSet & ~moved;
      if (moved != 32'h0000_0000) begin
        s_d.irqPulse = 1'b1;
      end
    end

    // APB access phase: writes; clears lose to sets arriving together
    if (apbWrite) begin
      case (paddr)
        `SPR_OFF_CTRL:     s_d.ctrl = pwdata;
        `SPR_OFF_STATUS: begin
          s_d.remErr = s_q.remErr && !pwdata[`SPR_STAT_REMERR];
          s_d.locErr = s_q.locErr && !pwdata[`SPR_STAT_LOCERR];
        end
        `SPR_OFF_PRIO: begin
          if (s_q.ctrl[`SPR_CTRL_LOCAL]) begin
            s_d.statClr[pwdata[4:0]] = 1'b0;
            s_d.statClr = s_d.statClr | moved;
          end
        end
        `SPR_OFF_STAT_CLR: begin
          s_d.statClr = (s_q.statClr & ~pwdata) | moved;
          if (s_d.statClr != 32'h0000_0000) begin
            s_d.irqPulse = 1'b1;
          end
        end
        `SPR_OFF_PEND_SET: s_d.pendSet = s_d.pendSet | pwdata;
        `SPR_OFF_PTR:      s_d.ptr = pwdata;
        default: begin
          if (mapped && (paddr >= `SPR_OFF_MAP_BASE)) begin
            if (mapIdx[0]) begin
              s_d.mapOff[mapIdx[3:1]] = pwdata;
            end else begin
              s_d.mapSize[mapIdx[3:1]] = pwdata;
            end
          end
        end
      endcase
    end

    // Error flags; a set beats a simultaneous write-one clear
    if (remSet) begin
      s_d.remErr = 1'b1;
    end
    if (locSet) begin
      s_d.locErr = 1'b1;
    end
    if ((remSet || locSet) && s_q.ctrl[`SPR_CTRL_ERREN]) begin
      s_d.pendSet[s_q.ctrl[`SPR_CTRL_ERRSEL]] = 1'b1;
    end

    // Software reset: engines idle, status to default, registers kept
    if (swRst) begin
      s_d.rxState  = RX_IDLE;
      s_d.txState  = TX_IDLE;
      s_d.paused   = 1'b0;
      s_d.qPush    = 1'b0;
      s_d.fcPause  = 1'b0;
      s_d.fcResume = 1'b0;
      s_d.remErr   = 1'b0;
      s_d.locErr   = 1'b0;
    end
  end

  // State register; hardware reset clears every register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q         <= '0;
      s_q.ctrl    <= `SPR_CTRL_RST;
      s_q.ptr     <= `SPR_PTR_RST;
      s_q.mapSize <= {4{`SPR_MAP_RST}};
      s_q.mapOff  <= {4{`SPR_MAP_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  // Address outside every region lands at zero
  xlate_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    rxDone && !swRst && (s_q.shift[71:64] == `SPR_PKT_WRITE) && (pktAddr >= runSum[3]) && qa.pushReady
    |=> s_q.qPush && (s_q.qAddr == 32'h0000_0000))
    else $error("out-of-map address not zero");

  // Second region subtracts the first size
  xlate_region_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    rxDone && !swRst && (s_q.shift[71:64] == `SPR_PKT_WRITE) && (pktAddr >= runSum[0]) &&
    (pktAddr < runSum[1]) && qa.pushReady
    |=> s_q.qAddr == $past(pktAddr) + $past(s_q.mapOff[1]) - $past(s_q.mapSize[0]))
    else $error("region two translation wrong");

  // Full storage raises a pause next cycle
  pause_full_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !s_q.paused && (qa.level == `SPR_Q_FULL) && !swRst |=> fcPause ##1 !fcPause)
    else $error("pause symbol missing");

  // Drained storage raises a resume next cycle
  resume_free_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.paused && (qa.level <= `SPR_RESUME_LEVEL) && !swRst |=> fcResume && !s_q.paused)
    else $error("resume symbol missing");

  // Software reset keeps the link off and the status clear
  swrst_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    swRst ##1 swRst |-> !linkEnable && !s_q.remErr && !s_q.locErr && (s_q.rxState == RX_IDLE))
    else $error("software reset not holding");

  // Local routing moves bits and pulses the line
  local_move_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.ctrl[`SPR_CTRL_LOCAL] && (s_q.pendSet != 32'h0000_0000) && !apbWrite
    |=> port_irq_out && ((s_q.statClr & $past(s_q.pendSet)) == $past(s_q.pendSet)))
    else $error("local interrupt hand-over failed");

  // Priority read flags an empty status/clear register
  none_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    psel && !penable && !pwrite && (paddr == `SPR_OFF_PRIO)
    |=> prdata[`SPR_PRIO_NONE] == $past(nonePend))
    else $error("none-pending flag wrong");

  // Enabled error posts its selected pending bit
  err_post_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.ctrl[`SPR_CTRL_ERREN] && !swRst && s_q.syncB[P_REM] && !s_q.pinPrev[P_REM] && !apbWrite
    |=> s_q.remErr && (s_q.pendSet[$past(s_q.ctrl[`SPR_CTRL_ERRSEL])] ||
        s_q.statClr[$past(s_q.ctrl[`SPR_CTRL_ERRSEL])]))
    else $error("error interrupt not posted");

  // Remote routing offers the pending word as a packet
  tx_offer_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !s_q.ctrl[`SPR_CTRL_LOCAL] && (s_q.txState == TX_IDLE) && (s_q.pendSet != 32'h0000_0000) && !swRst
    |=> txIrqValid && (txIrqData == $past(s_q.pendSet)))
    else $error("interrupt packet not offered");

endmodule

// ### tb/spr_peer_model.sv
// Remote peer: sends framed packets MSB first and idles while paused.
// Assumes pause and resume pulses last one ref_clk cycle.
`timescale 1ns/1ns
module spr_peer_model (
  input  wire logic ref_clk,
  input  wire logic fcPause,
  input  wire logic fcResume,
  output logic      linkClk,
  output logic      linkData,
  output logic      linkFrame
);
  logic held_q; // Peer has been told to pause
  initial {linkClk, linkData, linkFrame, held_q} = 4'h0;
  // Pause stops data, resume lets it flow
  always @(posedge ref_clk) held_q <= fcPause ? 1'b1 : (fcResume ? 1'b0 : held_q);
  // Clock stands still between frames; released data goes inverted
  task automatic send(input logic [71:0] p);
    for (int i = 71; i >= 0; i--) begin
      wait (held_q == 1'b0);
      linkFrame = 1'b1;
      linkData  = p[i];
      #62 linkClk = 1'b1;
      #63 linkClk = 1'b0;
    end
    linkFrame = 1'b0;
    linkData  = ~linkData;
    #125;
  endtask
endmodule

// ### tb/serial_port_rx_map_flow_irq_tb_top.sv
// Bench for spr_rx_top: APB master, peer model on the link, pulse counters.
// Assumes the design files are compiled first.
`timescale 1ns/1ns
module serial_port_rx_map_flow_irq_tb_top;
  logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr, linkClk, linkData, linkFrame;
  logic        linkUp, remoteErrIn, txIrqDone, linkEnable, fcPause, fcResume, txIrqValid;
  logic        port_irq_out, rdValid, rdReady, pe;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, txIrqData, rdAddr, rdData, r;
  int          err_total, check_count, irqN, pauseN, resN, n;
  spr_rx_top uut (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .linkClk, .linkData, .linkFrame, .linkUp, .remoteErrIn, .txIrqDone, .linkEnable, .fcPause, .fcResume,
    .txIrqValid, .txIrqData, .port_irq_out, .rdValid, .rdReady, .rdAddr, .rdData);
  spr_peer_model peer (.ref_clk, .fcPause, .fcResume, .linkClk, .linkData, .linkFrame);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // One-cycle pulses are counted, so no edge is missed
  always @(posedge ref_clk) begin
    irqN   <= irqN + 32'(port_irq_out === 1'b1);
    pauseN <= pauseN + 32'(fcPause === 1'b1);
    resN   <= resN + 32'(fcResume === 1'b1);
  end
  task chk(input string s, input logic [31:0] e, input logic [31:0] v);
    check_count++;
    if (v !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", s, e, v);
    end
  endtask
  task wt(input int k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // One APB transfer; read data lands in r
  task ap(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    pe = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Wait for a translated word, judge it, then take it
  task take(input logic [31:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    for (int k = 0; k < 400 && rdValid !== 1'b1; k++) @(negedge ref_clk);
    chk("rdValid", 32'h1, 32'(rdValid));
    chk("rdAddr", a, rdAddr);
    chk("rdData", d, rdData);
    @(posedge ref_clk) rdReady <= 1'b1;
    @(posedge ref_clk) rdReady <= 1'b0;
  endtask
  task t_map;
    ap(1'b1, 8'h20, 32'h100);
    ap(1'b1, 8'h24, 32'h0200_0000);
    ap(1'b1, 8'h28, 32'h100);
    ap(1'b1, 8'h2C, 32'h8200_0000);
    peer.send({8'h01, 32'h54, 32'hA});
    take(32'h0200_0054, 32'hA);
    peer.send({8'h01, 32'h154, 32'hB});
    take(32'h8200_0054, 32'hB);
    peer.send({8'h01, 32'h200, 32'hC});
    take(32'h0, 32'hC);
  endtask
  task t_flow;
    for (n = 0; n < 17 && pauseN == 0; n++) peer.send({8'h01, 32'h10, 32'(n)});
    wt(4);
    chk("pause", 32'h1, 32'(pauseN));
    chk("fill", 32'h1, 32'(n >= 16));
    for (int i = 0; i < n; i++) take(32'h0200_0010, 32'(i));
    wt(4);
    chk("resume", 32'h1, 32'(resN));
  endtask
  task t_local;
    ap(1'b1, 8'h04, 32'h4000);
    n = irqN;
    ap(1'b1, 8'h14, 32'h6);
    wt(3);
    chk("irq", 32'(n + 1), 32'(irqN));
    ap(1'b0, 8'h0C, 32'h0);
    chk("prio", 32'h1, r);
    ap(1'b1, 8'h0C, 32'h1);
    ap(1'b0, 8'h10, 32'h0);
    chk("statClr", 32'h4, r);
    n = irqN;
    ap(1'b1, 8'h10, 32'h0);
    wt(3);
    chk("irqAgain", 32'(n + 1), 32'(irqN));
    ap(1'b1, 8'h10, 32'h4);
    ap(1'b0, 8'h0C, 32'h0);
    chk("nonePend", 32'h8000_0000, r);
  endtask
  task t_remote;
    ap(1'b1, 8'h04, 32'h0);
    ap(1'b1, 8'h14, 32'h5);
    wt(3);
    chk("txIrqData", 32'h5, txIrqData & {32{txIrqValid}});
    @(posedge ref_clk) txIrqDone <= 1'b1;
    repeat (8) @(posedge ref_clk);
    txIrqDone <= 1'b0;
    ap(1'b0, 8'h14, 32'h0);
    chk("pendSet", 32'h0, r);
    ap(1'b1, 8'h18, 32'h14);
    ap(1'b1, 8'h04, 32'h6580);
    peer.send({8'h02, 32'h0, 32'h8});
    ap(1'b0, 8'h10, 32'h0);
    chk("remoteIrq", 32'h8, r);
  endtask
  task t_err;
    linkUp <= 1'b1;
    wt(8);
    ap(1'b0, 8'h08, 32'h0);
    chk("remErr", 32'h1, 32'(r[8]));
    ap(1'b0, 8'h10, 32'h0);
    chk("errIrq", 32'h28, r);
    ap(1'b1, 8'h08, 32'h100);
    ap(1'b0, 8'h08, 32'h0);
    chk("remErrClr", 32'h0, 32'(r[8]));
    remoteErrIn <= 1'b1;
    peer.send({8'h03, 64'h0});
    ap(1'b0, 8'h08, 32'h0);
    chk("errFlags", 32'h3, 32'(r[9:8]));
  endtask
  task t_swrst;
    ap(1'b1, 8'h04, 32'h6581);
    wt(1);
    chk("linkOff", 32'h0, 32'(linkEnable));
    ap(1'b0, 8'h18, 32'h0);
    chk("ptrKept", 32'h14, r);
    ap(1'b0, 8'h08, 32'h0);
    chk("statDefault", 32'h0, r);
    ap(1'b0, 8'h1C, 32'h0);
    chk("pslverr", 32'h1, 32'(pe));
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {nrst, psel, penable, pwrite, linkUp, remoteErrIn, txIrqDone, rdReady, paddr, pwdata} = 48'h0;
    {err_total, check_count, irqN, pauseN, resN} = '0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    wt(3);
    chk("linkOn", 32'h1, 32'(linkEnable));
    t_map;
    t_flow;
    t_local;
    t_remote;
    t_err;
    t_swrst;
    wrap_up;
  end
  // Watchdog well beyond the expected run
  initial begin
    #400000;
    err_total++;
    wrap_up;
  end
endmodule
